// File: hdl/arsc_pkg.sv
// Package: register map, field layout and carrier types for reference select control
package arsc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ARSC_ADDR_TEMP_OFFSET_VALUE_LOW  = 8'h85;
    localparam logic [7:0] ARSC_ADDR_TEMP_OFFSET_VALUE_HIGH = 8'h86;
    localparam logic [7:0] ARSC_ADDR_REF_CTRL  = 8'hD1;
    localparam logic [3:0] ARSC_PAGE_TEMP_OFFSET_VALUE      = 4'hF;
    localparam logic [3:0] ARSC_PAGE_REF_CTRL  = 4'h0;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         ARSC_BIT_PREF_EN = 0;
    localparam int         ARSC_BIT_SENS_EN = 2;
    localparam int         ARSC_LSB_REF_SEL = 3;
    localparam int         ARSC_BIT_GND_SEL = 5;
    localparam logic [7:0] ARSC_REF_CTRL_WMASK = 8'h3D;
    localparam logic [7:0] ARSC_REF_CTRL_RST   = 8'h18;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ARSC_REF_EXT_PIN  = 2'h0,
        ARSC_REF_MAIN_SUP = 2'h1,
        ARSC_REF_DIG_SUP  = 2'h2,
        ARSC_REF_HS_INT   = 2'h3
    } arsc_ref_sel_t;

    typedef enum logic {
        ARSC_GND_CHIP = 1'b0,
        ARSC_GND_PIN  = 1'b1
    } arsc_gnd_t;

    // Converter phase inputs
    typedef struct packed {
        logic busy;
        logic sampling;
        logic converting;
        logic sensor_chan;
    } arsc_conv_t;

    // Analog control outputs
    typedef struct packed {
        arsc_ref_sel_t ref_sel;
        logic          hs_ref_en;
        logic          pref_en;
        logic          sens_en;
        logic          sens_hiz;
        arsc_gnd_t     gnd_sel;
    } arsc_ana_t;

endpackage : arsc_pkg

// File: hdl/arsc_offset_store.sv
// Holds the factory temperature offset and its two read views
`timescale 1ns/10ps
`default_nettype none
module arsc_offset_store
    import arsc_pkg::*;
(
    input  wire logic       i_mclk,        // Core clock
    input  wire logic       i_rst,         // Synchronous reset
    input  wire logic [9:0] i_trim,        // Stored offset value
    output logic      [7:0] o_low_view,    // Low byte view, registered
    output logic      [7:0] o_high_view    // High byte view, registered
);

    // Reloaded from i_trim on every clock out of reset; the value is never writable
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_low_view  <= 8'h00;
            o_high_view <= 8'h00;
        end else begin
            o_low_view  <= {i_trim[1:0], 6'h00};  // RULE1 RULE2 RULE18
            o_high_view <= i_trim[9:2];           // RULE17 RULE18
        end
    end

endmodule : arsc_offset_store
`default_nettype wire

// File: hdl/arsc_ref_ctrl.sv
// Top: reference control register, offset reads and reference/ground steering
// Contract
// RULE1 - Offset low reads stored bits 1:0 at 7:6
// RULE2 - Offset low bits 5:0 zero; writes ignored
// RULE3 - Control bits 7:6 read zero, ignore writes
// RULE4 - Control bit 1 reads zero, ignores writes
// RULE5 - Bit 5 picks main or analog ground
// RULE6 - Bits 4:3 drive the reference mux
// RULE7 - High-speed reference on only while needed
// RULE8 - Bit 2 switches the temperature sensor
// RULE9 - Sensor output floats while disabled
// RULE10 - Bit 0 enables and connects precision reference
// RULE11 - Pin ground used in sampling and conversion
// RULE12 - Sensor sampling always uses chip ground
// RULE13 - High-speed reference conversion uses chip ground
// RULE14 - External reference: select 00, precision off
// RULE15 - Precision reference: enable set, select 00
// RULE16 - Enable precision reference before precision oscillator
// RULE17 - Offset high reads stored bits 9:2
// RULE18 - Offset is factory value, not writable
// RULE19 - One-cycle access; outputs update on write
`timescale 1ns/10ps
`default_nettype none
module arsc_ref_ctrl
    import arsc_pkg::*;
(
    input  wire logic       i_mclk,      // Core clock, 20 MHz
    input  wire logic       i_rst,       // Synchronous reset, active high
    input  wire logic [7:0] i_sfr_addr,  // Register address
    input  wire logic [3:0] i_sfr_page,  // Register page
    input  wire logic       i_sfr_wr,    // Write strobe
    input  wire logic       i_sfr_rd,    // Read strobe
    input  wire logic [7:0] i_sfr_wdata, // Write data
    output logic      [7:0] o_sfr_rdata, // Read data, combinational mux
    output logic            o_sfr_hit,   // Address decoded by this block
    input  wire logic [9:0] i_trim,      // Factory offset value
    input  wire arsc_conv_t i_conv,      // Converter phase status
    output arsc_ana_t       o_ana        // Analog controls
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic       sel_ctrl;
    logic       sel_low;
    logic       sel_high;
    logic [7:0] ctrl_q;
    logic [7:0] low_view;
    logic [7:0] high_view;

    // The page qualifies every address
    assign sel_ctrl  = (i_sfr_addr == ARSC_ADDR_REF_CTRL)  && (i_sfr_page == ARSC_PAGE_REF_CTRL);
    assign sel_low   = (i_sfr_addr == ARSC_ADDR_TEMP_OFFSET_VALUE_LOW)  && (i_sfr_page == ARSC_PAGE_TEMP_OFFSET_VALUE);
    assign sel_high  = (i_sfr_addr == ARSC_ADDR_TEMP_OFFSET_VALUE_HIGH) && (i_sfr_page == ARSC_PAGE_TEMP_OFFSET_VALUE);
    assign o_sfr_hit = sel_ctrl | sel_low | sel_high;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // Only the writable bits are stored
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ctrl_q <= ARSC_REF_CTRL_RST;                           // RULE19
        end else if (i_sfr_wr && sel_ctrl) begin
            ctrl_q <= i_sfr_wdata & ARSC_REF_CTRL_WMASK;           // RULE3 RULE4 RULE19
        end
    end

    arsc_offset_store arsc_offset_store_inst (
        .i_mclk      (i_mclk),
        .i_rst       (i_rst),
        .i_trim      (i_trim),
        .o_low_view  (low_view),
        .o_high_view (high_view)
    );

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // Idle, unmapped and off-page reads return zero
    always_comb begin
        o_sfr_rdata = 8'h00;
        if (i_sfr_rd) begin
            if (sel_ctrl) begin
                o_sfr_rdata = ctrl_q & ARSC_REF_CTRL_WMASK;        // RULE3 RULE4
            end else if (sel_low) begin
                o_sfr_rdata = low_view;                            // RULE1 RULE2
            end else if (sel_high) begin
                o_sfr_rdata = high_view;                           // RULE17
            end
        end
    end

    // ------------------------------------------------------------
    // Analog steering
    // ------------------------------------------------------------
    arsc_ref_sel_t ref_sel;
    logic          gnd_bit;
    logic          hs_sel;

    assign ref_sel = arsc_ref_sel_t'(ctrl_q[ARSC_LSB_REF_SEL +: 2]);
    assign gnd_bit = ctrl_q[ARSC_BIT_GND_SEL];
    assign hs_sel  = (ref_sel == ARSC_REF_HS_INT);

    // Busy stands for the converter's need of the high-speed reference
    // Later assignments win: both ground overrides beat the select bit
    always_comb begin
        o_ana.ref_sel   = ref_sel;                                 // RULE6
        o_ana.hs_ref_en = hs_sel && i_conv.busy;                   // RULE7
        o_ana.pref_en   = ctrl_q[ARSC_BIT_PREF_EN];                // RULE10
        o_ana.sens_en   = ctrl_q[ARSC_BIT_SENS_EN];                // RULE8
        o_ana.sens_hiz  = !ctrl_q[ARSC_BIT_SENS_EN];               // RULE9
        o_ana.gnd_sel   = gnd_bit ? ARSC_GND_PIN : ARSC_GND_CHIP;  // RULE5 RULE11
        if (i_conv.sampling && i_conv.sensor_chan) begin
            o_ana.gnd_sel = ARSC_GND_CHIP;                         // RULE12
        end
        if (i_conv.converting && hs_sel) begin
            o_ana.gnd_sel = ARSC_GND_CHIP;                         // RULE13
        end
    end

    // ------------------------------------------------------------
    // Register assertions
    // ------------------------------------------------------------
    ctrl_write_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE19
        i_sfr_wr && sel_ctrl |=> ctrl_q == ($past(i_sfr_wdata) & ARSC_REF_CTRL_WMASK))
        else $error("control write not stored");
    ctrl_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE19
        !(i_sfr_wr && sel_ctrl) |=> $stable(ctrl_q))
        else $error("control register changed without a write");
    offs_write_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE18
        i_sfr_wr && (sel_low || sel_high) |=> $stable(ctrl_q))
        else $error("offset write disturbed control register");
    ctrl_reset_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE19
        $past(i_rst) |-> ctrl_q == ARSC_REF_CTRL_RST)
        else $error("control register not at reset value");
    unused_zero_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE3 RULE4
        i_sfr_rd && sel_ctrl |-> o_sfr_rdata[7:6] == 2'h0 && !o_sfr_rdata[1])
        else $error("unused control bits not zero");
    rd_ctrl_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE19
        i_sfr_rd && sel_ctrl |-> o_sfr_rdata == ctrl_q)
        else $error("control read data wrong");
    miss_read_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE19
        !(i_sfr_rd && o_sfr_hit) |-> o_sfr_rdata == 8'h00)
        else $error("read data without a decoded read");
    zero_low_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE2
        i_sfr_rd && sel_low |-> o_sfr_rdata[5:0] == 6'h00)
        else $error("offset low unused bits not zero");
    // Offset views load one edge after reset release
    low_view_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE1 RULE2
        i_sfr_rd && sel_low && $stable(i_trim) && !$past(i_rst)
        |-> o_sfr_rdata == {i_trim[1:0], 6'h00})
        else $error("offset low view wrong");
    high_view_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE17
        i_sfr_rd && sel_high && $stable(i_trim) && !$past(i_rst)
        |-> o_sfr_rdata == i_trim[9:2])
        else $error("offset high view wrong");
    pref_en_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE10
        i_sfr_wr && sel_ctrl |=> o_ana.pref_en == $past(i_sfr_wdata[0]))
        else $error("precision enable not updated");

    // ------------------------------------------------------------
    // Steering assertions
    // ------------------------------------------------------------
    ref_mux_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE6
        o_ana.ref_sel == ctrl_q[ARSC_LSB_REF_SEL +: 2])
        else $error("reference mux select wrong");
    hs_gate_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE7
        o_ana.hs_ref_en == (ctrl_q[4:3] == 2'h3 && i_conv.busy))
        else $error("high-speed reference gating wrong");
    hs_idle_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE7
        !i_conv.busy || ctrl_q[4:3] != 2'h3 |-> !o_ana.hs_ref_en)
        else $error("high-speed reference on while not needed");
    pref_out_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE10
        o_ana.pref_en == ctrl_q[ARSC_BIT_PREF_EN])
        else $error("precision enable differs from its bit");
    sens_en_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE8
        o_ana.sens_en == ctrl_q[ARSC_BIT_SENS_EN])
        else $error("sensor enable differs from its bit");
    sens_hiz_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE8 RULE9
        o_ana.sens_hiz != ctrl_q[2])
        else $error("sensor enable and float disagree");

    // ------------------------------------------------------------
    // Ground assertions
    // ------------------------------------------------------------
    // Ground overrides outrank the select bit
    main_gnd_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE5
        !ctrl_q[ARSC_BIT_GND_SEL] |-> o_ana.gnd_sel == ARSC_GND_CHIP)
        else $error("main ground not selected");
    pin_gnd_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE5 RULE11
        ctrl_q[5] && !i_conv.sampling && !i_conv.converting |-> o_ana.gnd_sel == ARSC_GND_PIN)
        else $error("ground select ignored");
    samp_pin_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE11
        ctrl_q[5] && i_conv.sampling && !i_conv.sensor_chan
        && !(i_conv.converting && ctrl_q[4:3] == 2'h3) |-> o_ana.gnd_sel == ARSC_GND_PIN)
        else $error("pin ground not used while sampling");
    conv_pin_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE11
        ctrl_q[5] && i_conv.converting && ctrl_q[4:3] != 2'h3
        && !(i_conv.sampling && i_conv.sensor_chan) |-> o_ana.gnd_sel == ARSC_GND_PIN)
        else $error("pin ground not used while converting");
    samp_gnd_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE12
        i_conv.sampling && i_conv.sensor_chan |-> o_ana.gnd_sel == ARSC_GND_CHIP)
        else $error("sensor sampling not on chip ground");
    conv_gnd_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RULE13
        i_conv.converting && ctrl_q[4:3] == 2'h3 |-> o_ana.gnd_sel == ARSC_GND_CHIP)
        else $error("high-speed conversion not on chip ground");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    cov_hs_c: cover property (@(posedge i_mclk) disable iff (i_rst) o_ana.hs_ref_en);
    cov_pin_c: cover property (@(posedge i_mclk) disable iff (i_rst)
        i_conv.converting && o_ana.gnd_sel == ARSC_GND_PIN);
    cov_sens_c: cover property (@(posedge i_mclk) disable iff (i_rst)
        i_conv.sampling && i_conv.sensor_chan && ctrl_q[5]);
    cov_ext_c: cover property (@(posedge i_mclk) disable iff (i_rst)
        o_ana.ref_sel == ARSC_REF_EXT_PIN && !o_ana.pref_en);
    cov_pref_c: cover property (@(posedge i_mclk) disable iff (i_rst)
        o_ana.ref_sel == ARSC_REF_EXT_PIN && o_ana.pref_en);

endmodule : arsc_ref_ctrl
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the reference select control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
    import arsc_pkg::*;
    logic        i_mclk      = 1'b0;
    logic        i_rst       = 1'b1;
    logic [7:0]  i_sfr_addr  = 8'h00;
    logic [3:0]  i_sfr_page  = 4'h0;
    logic        i_sfr_wr    = 1'b0;
    logic        i_sfr_rd    = 1'b0;
    logic [7:0]  i_sfr_wdata = 8'h00;
    logic [9:0]  i_trim      = 10'h000;
    arsc_conv_t  i_conv      = '0;
    logic [7:0]  o_sfr_rdata;
    logic        o_sfr_hit;
    arsc_ana_t   o_ana;
    logic [7:0]  ctrl_q      = 8'h18;
    logic [15:0] exp_q[$];
    logic [15:0] note;
    int          fails       = 0;
    int          n_compared  = 0;

    arsc_ref_ctrl arsc_ref_ctrl_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr),
        .i_sfr_page(i_sfr_page), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
        .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit),
        .i_trim(i_trim), .i_conv(i_conv), .o_ana(o_ana));

    initial begin
        forever #25 i_mclk = ~i_mclk;
    end

    // ------------------------------------------------------------
    // Expected read data, analog controls and hit
    // ------------------------------------------------------------
    function automatic logic [15:0] expect_of(logic [7:0] a, logic [3:0] p, arsc_conv_t c);
        logic [7:0] d;
        logic       h;
        logic       g;
        d = 8'h00;
        h = 1'b1;
        if (p == 4'hF && a == 8'h85) d = {i_trim[1:0], 6'h00};
        else if (p == 4'hF && a == 8'h86) d = i_trim[9:2];
        else if (p == 4'h0 && a == 8'hD1) d = ctrl_q;
        else h = 1'b0;
        g = ctrl_q[5] && !(c.sampling && c.sensor_chan) && !(c.converting && ctrl_q[4:3] == 2'h3);
        return {d, ctrl_q[4:3], ctrl_q[4:3] == 2'h3 && c.busy, ctrl_q[0], ctrl_q[2], !ctrl_q[2],
                g, h};
    endfunction : expect_of

    // One bus cycle; writes update the model, reads leave a note
    task automatic op(input logic w, input logic [7:0] a, input logic [3:0] p,
                      input logic [7:0] d, input arsc_conv_t c);
        @(posedge i_mclk);
        i_sfr_wr    <= w;
        i_sfr_rd    <= !w;
        i_sfr_addr  <= a;
        i_sfr_page  <= p;
        i_sfr_wdata <= d;
        i_conv      <= c;
        if (w && p == 4'h0 && a == 8'hD1) ctrl_q = d & 8'h3D;
        else if (!w) exp_q.push_back(expect_of(a, p, c));
    endtask : op

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge i_mclk);
            i_sfr_wr <= 1'b0;
            i_sfr_rd <= 1'b0;
        end
    endtask : idle

    task automatic results();
        $display("compared=%0d failed=%0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    // Result watcher: reads settle mid-cycle
    always @(negedge i_mclk) begin
        if (i_sfr_rd === 1'b1) begin
            note = exp_q.pop_front();
            `CHK({o_sfr_rdata, o_ana, o_sfr_hit}, note)
        end
    end

    initial begin
        repeat (2000) @(posedge i_mclk);
        fails++;
        results();
    end

    initial begin
        logic [7:0] d;
        d = 8'($urandom(32'h02165353));
        i_trim <= 10'($urandom());
        idle(16);
        i_rst <= 1'b0;
        idle(2);
        op(1'b0, 8'hD1, 4'h0, 8'h00, '0);
        op(1'b0, 8'h85, 4'hF, 8'h00, '0);
        op(1'b0, 8'h86, 4'hF, 8'h00, '0);
        op(1'b1, 8'hD1, 4'h0, 8'hFF, '0);
        op(1'b0, 8'hD1, 4'h0, 8'h00, '0);
        op(1'b1, 8'h85, 4'hF, 8'hFF, '0);
        op(1'b1, 8'h86, 4'hF, 8'hFF, '0);
        op(1'b1, 8'hD1, 4'hF, 8'h00, '0);
        op(1'b0, 8'h85, 4'hF, 8'h00, '0);
        op(1'b0, 8'h86, 4'hF, 8'h00, '0);
        op(1'b0, 8'hD1, 4'hF, 8'h00, '0);
        op(1'b0, 8'h00, 4'h0, 8'h00, '0);
        op(1'b0, 8'hD1, 4'h0, 8'h00, '0);
        // External reference, then precision reference enabled, each read back while busy
        op(1'b1, 8'hD1, 4'h0, 8'h00, '0);
        op(1'b0, 8'hD1, 4'h0, 8'h00, 4'h8);
        op(1'b1, 8'hD1, 4'h0, 8'h01, '0);
        op(1'b0, 8'hD1, 4'h0, 8'h00, 4'h8);
        // Every reference select against every converter phase
        for (int s = 0; s < 4; s++) begin
            for (int c = 0; c < 16; c++) begin
                d = 8'($urandom());
                d[4:3] = 2'(s);
                op(1'b1, 8'hD1, 4'h0, d, 4'($urandom()));
                op(1'b0, 8'hD1, 4'h0, 8'h00, 4'(c));
            end
        end
        // Reset in mid-run restores the control register
        idle(1);
        i_rst <= 1'b1;
        ctrl_q = 8'h18;
        idle(3);
        i_rst <= 1'b0;
        idle(2);
        op(1'b0, 8'hD1, 4'h0, 8'h00, 4'hF);
        op(1'b0, 8'h85, 4'hF, 8'h00, '0);
        idle(2);
        results();
    end
endmodule : testbench
`default_nettype wire
